// *** design/lir_defines.svh ***
`ifndef LIR_DEFINES_SVH
`define LIR_DEFINES_SVH

// ------------------------------------------------------------
// parameter numbers (menu * 100 + parameter)
// ------------------------------------------------------------
`define LIR_IDX_IN8_STATE     12'h328
`define LIR_IDX_IN9_STATE     12'h329
`define LIR_IDX_IN10_STATE    12'h32a
`define LIR_IDX_TARGET_BASE   12'h32c
`define LIR_IDX_FIXED_DIS     12'h335
`define LIR_IDX_POL_BASE      12'h336
`define LIR_IDX_JOG_REV_ALLOW 12'h33f
`define LIR_IDX_JOG_FWD_ALLOW 12'h340
`define LIR_IDX_RUN_REV_ALLOW 12'h341
`define LIR_IDX_RUN_FWD_ALLOW 12'h342
`define LIR_IDX_SER_REF_ON    12'h06f
`define LIR_IDX_SER_DIR       12'h070

// ------------------------------------------------------------
// destination codes and limits
// ------------------------------------------------------------
`define LIR_DEST_MAX          11'h7cf
`define LIR_DEST_REF_ON       11'h06f
`define LIR_DEST_DIR          11'h070
`define LIR_DEST_JOG_REV      11'h071
`define LIR_DEST_JOG_FWD      11'h072
`define LIR_DEST_RESET        11'h000
`define LIR_BIT_RESET         1'h0

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define LIR_CLK_HZ            40000000
`define LIR_OFF_DELAY_MS      30
`define LIR_OFF_DELAY_CYCLES  ((`LIR_OFF_DELAY_MS * `LIR_CLK_HZ) / 1000)

`endif

// *** design/lir_pkg.sv ***
package lir_pkg;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef logic [10:0] lir_dest_t;

    // drive commands produced by the block
    typedef struct packed {
        logic ref_on;
        logic reverse;
        logic jog_fwd;
        logic jog_rev;
    } lir_cmd_t;

    // drive-enable supervisor states
    typedef enum logic [2:0] {
        EN_ON   = 3'h1,
        EN_WAIT = 3'h2,
        EN_OFF  = 3'h4
    } lir_en_state_t;

endpackage

// *** design/lir_top.sv ***
`timescale 1ns/1ps
`include "lir_defines.svh"

module lir_top
    import lir_pkg::*;
#(
    parameter int OFF_CYCLES = `LIR_OFF_DELAY_CYCLES
) (
    // clock and reset
    input  wire logic              i_clock,
    input  wire logic              i_sys_rst,
    // terminals, bit 0 is input two
    input  wire logic [8:0]        i_logic_in,
    input  wire logic              i_drive_enable,
    input  wire logic              i_start_permit,
    input  wire logic              i_run_permit,
    input  wire logic              i_drive_reset,
    // parameter access
    input  wire logic              i_par_wr,
    input  wire logic              i_par_rd,
    input  wire logic [11:0]       i_par_index,
    input  wire logic [10:0]       i_par_wdata,
    output logic      [10:0]       o_par_rdata,
    output logic                   o_par_ack,
    // drive side
    output lir_cmd_t               o_cmd,
    output logic                   o_firing_en,
    output logic                   o_coast_stop,
    output logic                   o_ramp_reset,
    output logic                   o_preramp_zero,
    output logic      [8:0]        o_route_level,
    output lir_dest_t [8:0]        o_route_dest
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    lir_dest_t [8:0] tgt_q;
    logic      [8:0] pol_q;
    logic            ffd_q;
    logic      [3:0] allow_q;       // jog rev, jog fwd, run rev, run fwd
    logic            ser_ref_q;
    logic            ser_dir_q;
    logic            load_q;
    logic            en_prev_q;
    lir_en_state_t   en_st_q;
    logic      [20:0] cnt_q;
    logic      [8:0] inv;
    logic      [8:0] hit_ref;
    logic      [8:0] hit_dir;
    logic      [8:0] hit_jr;
    logic      [8:0] hit_jf;
    logic      [8:0] wr_tgt;
    logic      [8:0] wr_pol;
    logic            dest_ok;
    logic            rd_tgt_hit;
    logic      [3:0] rd_k;

    assign dest_ok = (i_par_wdata <= `LIR_DEST_MAX);

    // ------------------------------------------------------------
    // per-input polarity, decode and routing hits
    // ------------------------------------------------------------
    for (genvar k = 0; k < 9; k++) begin : g_in
        // inversion first, decode, routing hits and route level see inv; status reads use raw terminals
        assign inv[k]     = i_logic_in[k] ^ pol_q[k];
        assign wr_tgt[k]  = i_par_wr && (i_par_index == `LIR_IDX_TARGET_BASE + 12'(k));
        assign wr_pol[k]  = i_par_wr && (i_par_index == `LIR_IDX_POL_BASE + 12'(k));
        assign hit_ref[k] = inv[k] && (o_route_dest[k] == `LIR_DEST_REF_ON);
        assign hit_dir[k] = inv[k] && (o_route_dest[k] == `LIR_DEST_DIR);
        assign hit_jr[k]  = inv[k] && (o_route_dest[k] == `LIR_DEST_JOG_REV);
        assign hit_jf[k]  = inv[k] && (o_route_dest[k] == `LIR_DEST_JOG_FWD);

        // pending destination, range checked
        always_ff @(posedge i_clock or posedge i_sys_rst) begin
            if (i_sys_rst) begin
                tgt_q[k] <= `LIR_DEST_RESET;
            end else if (wr_tgt[k] && dest_ok) begin
                tgt_q[k] <= i_par_wdata;
            end
        end

        // inversion bit
        always_ff @(posedge i_clock or posedge i_sys_rst) begin
            if (i_sys_rst) begin
                pol_q[k] <= `LIR_BIT_RESET;
            end else if (wr_pol[k]) begin
                pol_q[k] <= i_par_wdata[0];
            end
        end

        // active destination, copied only on reset
        always_ff @(posedge i_clock or posedge i_sys_rst) begin
            if (i_sys_rst) begin
                o_route_dest[k] <= `LIR_DEST_RESET;
            end else if (load_q) begin
                o_route_dest[k] <= tgt_q[k];
            end
        end
    end

    // ------------------------------------------------------------
    // reset-time load of destinations
    // ------------------------------------------------------------
    // set by power-on or drive reset, consumed one cycle later
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            load_q <= 1'h1;
        end else begin
            load_q <= i_drive_reset;
        end
    end

    // ------------------------------------------------------------
    // single-bit parameters
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ffd_q   <= `LIR_BIT_RESET;
            allow_q <= 4'h0;
        end else if (i_par_wr) begin
            case (i_par_index)
                `LIR_IDX_FIXED_DIS:     ffd_q      <= i_par_wdata[0];
                `LIR_IDX_JOG_REV_ALLOW: allow_q[3] <= i_par_wdata[0];
                `LIR_IDX_JOG_FWD_ALLOW: allow_q[2] <= i_par_wdata[0];
                `LIR_IDX_RUN_REV_ALLOW: allow_q[1] <= i_par_wdata[0];
                `LIR_IDX_RUN_FWD_ALLOW: allow_q[0] <= i_par_wdata[0];
                default: ;
            endcase
        end
    end

    // serial run control, accepted only with fixed map off
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ser_ref_q <= 1'h0;
            ser_dir_q <= 1'h0;
        end else if (i_par_wr && ffd_q) begin
            if (i_par_index == `LIR_IDX_SER_REF_ON) begin
                ser_ref_q <= i_par_wdata[0];
            end
            if (i_par_index == `LIR_IDX_SER_DIR) begin
                ser_dir_q <= i_par_wdata[0];
            end
        end
    end

    // ------------------------------------------------------------
    // parameter read-back, one cycle latency
    // ------------------------------------------------------------
    assign rd_tgt_hit = (i_par_index >= `LIR_IDX_TARGET_BASE)
                        && (i_par_index < `LIR_IDX_TARGET_BASE + 12'h009);
    assign rd_k       = 4'(i_par_index - `LIR_IDX_TARGET_BASE);

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_par_rdata <= 11'h000;
            o_par_ack   <= 1'h0;
        end else begin
            o_par_ack <= i_par_rd || i_par_wr;
            if (i_par_rd) begin
                case (i_par_index)
                    `LIR_IDX_IN8_STATE:     o_par_rdata <= {10'h000, i_logic_in[6]};
                    `LIR_IDX_IN9_STATE:     o_par_rdata <= {10'h000, i_logic_in[7]};
                    `LIR_IDX_IN10_STATE:    o_par_rdata <= {10'h000, i_logic_in[8]};
                    `LIR_IDX_FIXED_DIS:     o_par_rdata <= {10'h000, ffd_q};
                    `LIR_IDX_JOG_REV_ALLOW: o_par_rdata <= {10'h000, allow_q[3]};
                    `LIR_IDX_JOG_FWD_ALLOW: o_par_rdata <= {10'h000, allow_q[2]};
                    `LIR_IDX_RUN_REV_ALLOW: o_par_rdata <= {10'h000, allow_q[1]};
                    `LIR_IDX_RUN_FWD_ALLOW: o_par_rdata <= {10'h000, allow_q[0]};
                    `LIR_IDX_SER_REF_ON:    o_par_rdata <= {10'h000, ser_ref_q};
                    `LIR_IDX_SER_DIR:       o_par_rdata <= {10'h000, ser_dir_q};
                    default: begin
                        if (rd_tgt_hit) begin
                            o_par_rdata <= tgt_q[rd_k];
                        end else if ((i_par_index >= `LIR_IDX_POL_BASE)
                                     && (i_par_index < `LIR_IDX_POL_BASE + 12'h009)) begin
                            o_par_rdata <= {10'h000, pol_q[4'(i_par_index - `LIR_IDX_POL_BASE)]};
                        end else begin
                            o_par_rdata <= 11'h000;
                        end
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // drive-enable supervisor
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            en_st_q     <= EN_OFF;
            cnt_q       <= 21'h000000;
            o_firing_en <= 1'h0;
        end else begin
            case (en_st_q)
                EN_ON: begin
                    if (!i_drive_enable) begin
                        en_st_q <= EN_WAIT;
                        cnt_q   <= 21'h000000;
                    end
                end
                EN_WAIT: begin
                    if (i_drive_enable) begin
                        en_st_q <= EN_ON;
                    end else if (cnt_q == 21'(OFF_CYCLES - 1)) begin
                        en_st_q     <= EN_OFF;
                        o_firing_en <= 1'h0;
                    end else begin
                        cnt_q <= cnt_q + 21'h000001;
                    end
                end
                EN_OFF: begin
                    if (i_drive_enable) begin
                        en_st_q     <= EN_ON;
                        o_firing_en <= 1'h1;
                    end
                end
                default: begin
                    en_st_q     <= EN_OFF;
                    o_firing_en <= 1'h0;
                end
            endcase
        end
    end

    // coast stop and ramp reset when enable drops while running
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            en_prev_q    <= 1'h0;
            o_coast_stop <= 1'h0;
            o_ramp_reset <= 1'h0;
        end else begin
            en_prev_q    <= i_drive_enable;
            o_coast_stop <= en_prev_q && !i_drive_enable && o_cmd.ref_on;
            o_ramp_reset <= en_prev_q && !i_drive_enable && o_cmd.ref_on;
        end
    end

    // ------------------------------------------------------------
    // command generation
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_cmd          <= '0;
            o_preramp_zero <= 1'h1;
            o_route_level  <= 9'h000;
        end else begin
            o_preramp_zero <= !i_start_permit;
            o_route_level  <= inv;
            // nothing runs while the enable terminal is open
            if (!i_start_permit || !i_drive_enable) begin
                o_cmd.ref_on <= 1'h0;
                o_cmd.jog_rev <= 1'h0;
                o_cmd.jog_fwd <= 1'h0;
            end else if (!ffd_q) begin
                o_cmd.jog_rev <= inv[0];
                o_cmd.jog_fwd <= inv[1];
                if (inv[2] || inv[3]) begin
                    o_cmd.ref_on  <= 1'h1;
                    o_cmd.reverse <= inv[2];
                end
            end else begin
                // fixed map off: routed inputs and serial writes only
                o_cmd.jog_rev <= allow_q[3] && (|hit_jr);
                o_cmd.jog_fwd <= allow_q[2] && (|hit_jf);
                o_cmd.reverse <= ser_dir_q || (|hit_dir);
                o_cmd.ref_on  <= (ser_ref_q || ((|hit_ref) && i_run_permit))
                                 && ((ser_dir_q || (|hit_dir)) ? allow_q[1] : allow_q[0]);
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_enable_drop;
        en_prev_q && !i_drive_enable && o_cmd.ref_on;
    endsequence

    sequence s_delay_done;
        (en_st_q == EN_WAIT) && !i_drive_enable && (cnt_q == 21'(OFF_CYCLES - 1));
    endsequence

    chk_status_read: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (i_par_rd && i_par_index == `LIR_IDX_IN9_STATE) |=> o_par_rdata == {10'h000, $past(i_logic_in[7])})
        else $error("status read does not match terminal");

    chk_fire_off: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        s_delay_done |=> !o_firing_en ##1 (!o_firing_en || i_drive_enable))
        else $error("firing still on after delay");

    chk_fire_hold: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (en_st_q == EN_ON && !i_drive_enable) |=> o_firing_en)
        else $error("firing cut before delay");

    chk_coast_stop: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        s_enable_drop |=> o_coast_stop && o_ramp_reset && !o_cmd.ref_on)
        else $error("no coast stop on enable loss");

    chk_dest_range: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (wr_tgt[0] && !dest_ok) |=> $stable(tgt_q[0]))
        else $error("out of range destination stored");

    chk_dest_hold: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        !load_q |=> $stable(o_route_dest))
        else $error("destination changed without reset");

    chk_fixed_map: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (!ffd_q && i_start_permit && i_drive_enable)
        |=> o_cmd.jog_fwd == $past(inv[1]))
        else $error("fixed inch forward mapping wrong");

    chk_enable_gate: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        !i_drive_enable |=> !o_cmd.ref_on)
        else $error("reference on while drive disabled");

    chk_run_permit: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (ffd_q && !i_run_permit && !ser_ref_q) |=> !o_cmd.ref_on)
        else $error("reference on without run permit");

    chk_jog_allow: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (ffd_q && !allow_q[3]) |=> !o_cmd.jog_rev)
        else $error("inch reverse without allow");

    chk_run_latch: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (!ffd_q && o_cmd.ref_on && i_start_permit && i_drive_enable)
        |=> o_cmd.ref_on)
        else $error("run command not latched");

    chk_permit_zero: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        !i_start_permit |=> o_preramp_zero && !o_cmd.ref_on)
        else $error("permit loss did not zero reference");

endmodule // lir_top

// *** testbench/lir_switch_model.sv ***
`timescale 1ns/1ps

module lir_switch_model
    import lir_pkg::*;
(
    // clock
    input  wire logic       i_clock,
    // requested contact states
    input  wire logic [8:0] i_want_in,
    input  wire logic       i_want_enable,
    input  wire logic       i_want_start,
    input  wire logic       i_want_run,
    // terminal levels
    output logic      [8:0] o_logic_in,
    output logic            o_drive_enable,
    output logic            o_start_permit,
    output logic            o_run_permit
);
    // contacts open at power-up
    initial begin
        o_logic_in     = 9'h000;
        o_drive_enable = 1'h0;
        o_start_permit = 1'h0;
        o_run_permit   = 1'h0;
    end

    // contacts move just after an edge, then hold
    always @(posedge i_clock) begin
        o_logic_in     <= i_want_in;
        o_drive_enable <= i_want_enable;
        o_start_permit <= i_want_start;
        o_run_permit   <= i_want_run;
    end
endmodule // lir_switch_model

// *** testbench/test_logic_input_routing.sv ***
`timescale 1ns/1ps

module test_logic_input_routing;
    import lir_pkg::*;
    localparam int OFF = 20;
    logic       i_clock = 1'h0;
    logic       i_sys_rst = 1'h1;
    logic [8:0] want_in = 9'h000;
    logic       want_en = 1'h1, want_start = 1'h1, want_run = 1'h0;
    logic       drv_rst = 1'h0, par_wr = 1'h0, par_rd = 1'h0;
    logic [11:0] par_index = 12'h000;
    logic [10:0] par_wdata = 11'h000, par_rdata, rd_v;
    logic [8:0] logic_in, route_level;
    logic       drive_en, start_ok, run_ok, par_ack, firing, coast, ramp, pre_zero;
    lir_cmd_t   cmd;
    lir_dest_t [8:0] route_dest;
    int         bad_count = 0, cmp_count = 0;

    always #12.5 i_clock = ~i_clock;

    lir_switch_model i_lir_switch_model (.i_clock(i_clock), .i_want_in(want_in),
        .i_want_enable(want_en), .i_want_start(want_start), .i_want_run(want_run),
        .o_logic_in(logic_in), .o_drive_enable(drive_en), .o_start_permit(start_ok),
        .o_run_permit(run_ok));

    lir_top #(.OFF_CYCLES(OFF)) i_lir_top (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
        .i_logic_in(logic_in), .i_drive_enable(drive_en), .i_start_permit(start_ok),
        .i_run_permit(run_ok), .i_drive_reset(drv_rst), .i_par_wr(par_wr),
        .i_par_rd(par_rd), .i_par_index(par_index), .i_par_wdata(par_wdata),
        .o_par_rdata(par_rdata), .o_par_ack(par_ack), .o_cmd(cmd), .o_firing_en(firing),
        .o_coast_stop(coast), .o_ramp_reset(ramp), .o_preramp_zero(pre_zero),
        .o_route_level(route_level), .o_route_dest(route_dest));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task check(input logic [10:0] seen, input logic [10:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task end_sim;
        if (bad_count == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // strobe one access, answer lands one edge later
    task par_acc(input logic wr, input logic [11:0] idx, input logic [10:0] d);
        @(posedge i_clock);
        par_wr    <= wr;
        par_rd    <= !wr;
        par_index <= idx;
        par_wdata <= d;
        @(posedge i_clock);
        par_wr <= 1'h0;
        par_rd <= 1'h0;
        #1;
        check(par_ack, 11'h001);
        rd_v = par_rdata;
    endtask

    task rd_chk(input logic [11:0] idx, input logic [10:0] exp);
        par_acc(1'h0, idx, 11'h000);
        check(rd_v, exp);
    endtask

    task settle;
        repeat (3) @(posedge i_clock);
        #1;
    endtask

    task set_in(input logic [8:0] v);
        @(posedge i_clock);
        want_in <= v;
        settle();
    endtask

    task pulse_reset;
        @(posedge i_clock);
        drv_rst <= 1'h1;
        @(posedge i_clock);
        drv_rst <= 1'h0;
        settle();
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (7) @(posedge i_clock);
        #1;
        check(pre_zero, 11'h001);
        @(posedge i_clock);
        i_sys_rst <= 1'h0;
        settle();
        for (int k = 0; k < 23; k++)
            rd_chk(12'h32c + k[11:0], 11'h000);
        rd_chk(12'h3ff, 11'h000);
        // status bits follow raw terminals, writes refused
        set_in(9'h140);
        rd_chk(12'h328, 11'h001);
        rd_chk(12'h329, 11'h000);
        rd_chk(12'h32a, 11'h001);
        par_acc(1'h1, 12'h328, 11'h000);
        rd_chk(12'h328, 11'h001);
        set_in(9'h000);
        // inverted input two acts as inch reverse
        par_acc(1'h1, 12'h336, 11'h001);
        rd_chk(12'h336, 11'h001);
        settle();
        check(route_level, 11'h001);
        check(cmd, 11'h001);
        par_acc(1'h1, 12'h336, 11'h000);
        set_in(9'h002);
        check(cmd, 11'h002);
        set_in(9'h004);
        set_in(9'h000);
        check(cmd, 11'h00c);
        set_in(9'h008);
        set_in(9'h000);
        check(cmd, 11'h008);
        // permit loss drops the latched run
        @(posedge i_clock);
        want_start <= 1'h0;
        settle();
        check(cmd, 11'h000);
        check(pre_zero, 11'h001);
        set_in(9'h008);
        check(cmd, 11'h000);
        @(posedge i_clock);
        want_start <= 1'h1;
        set_in(9'h000);
        check(pre_zero, 11'h000);
        // destinations: range limit, applied only at reset
        par_acc(1'h1, 12'h32c, 11'h7cf);
        par_acc(1'h1, 12'h32c, 11'h7d0);
        rd_chk(12'h32c, 11'h7cf);
        settle();
        check(route_dest[0], 11'h000);
        pulse_reset();
        check(route_dest[0], 11'h7cf);
        // serial run control refused while fixed map is on
        par_acc(1'h1, 12'h06f, 11'h001);
        rd_chk(12'h06f, 11'h000);
        // programmed mode
        par_acc(1'h1, 12'h335, 11'h001);
        rd_chk(12'h335, 11'h001);
        par_acc(1'h1, 12'h330, 11'h06f);
        par_acc(1'h1, 12'h331, 11'h071);
        par_acc(1'h1, 12'h332, 11'h072);
        pulse_reset();
        par_acc(1'h1, 12'h342, 11'h001);
        set_in(9'h00f);
        check(cmd, 11'h000);
        set_in(9'h010);
        check(cmd, 11'h000);
        @(posedge i_clock);
        want_run <= 1'h1;
        settle();
        check(cmd, 11'h008);
        par_acc(1'h1, 12'h342, 11'h000);
        settle();
        check(cmd, 11'h000);
        par_acc(1'h1, 12'h342, 11'h001);
        par_acc(1'h1, 12'h070, 11'h001);
        settle();
        check(cmd, 11'h004);
        par_acc(1'h1, 12'h341, 11'h001);
        settle();
        check(cmd, 11'h00c);
        set_in(9'h070);
        check(cmd, 11'h00c);
        par_acc(1'h1, 12'h33f, 11'h001);
        settle();
        check(cmd, 11'h00d);
        par_acc(1'h1, 12'h340, 11'h001);
        settle();
        check(cmd, 11'h00f);
        set_in(9'h000);
        par_acc(1'h1, 12'h06f, 11'h001);
        settle();
        check(cmd, 11'h00c);
        // enable drop while running
        @(posedge i_clock);
        want_en <= 1'h0;
        @(posedge i_clock);
        repeat (1) @(posedge i_clock);
        #1;
        check(coast, 11'h001);
        check(ramp, 11'h001);
        @(posedge i_clock);
        #1;
        check(coast, 11'h000);
        check(cmd, 11'h004);
        repeat (OFF - 2) @(posedge i_clock);
        #1;
        check(firing, 11'h001);
        @(posedge i_clock);
        #1;
        check(firing, 11'h000);
        @(posedge i_clock);
        want_en <= 1'h1;
        repeat (4) @(posedge i_clock);
        #1;
        check(firing, 11'h001);
        // short drop is cancelled before the shut-off
        @(posedge i_clock);
        want_en <= 1'h0;
        repeat (5) @(posedge i_clock);
        want_en <= 1'h1;
        repeat (OFF + 4) @(posedge i_clock);
        #1;
        check(firing, 11'h001);
        end_sim();
    end

    // watchdog, tests need well under 2000 cycles
    initial begin
        repeat (4000) @(posedge i_clock);
        bad_count++;
        end_sim();
    end
endmodule // test_logic_input_routing
